//--- pkg/sse_consts.vh
// Constants of the status synchronisation engine.
`ifndef SSE_CONSTS_VH
`define SSE_CONSTS_VH

// Command numbers used on both links.
`define SSE_CMD_OWN_IND     16'hfc06
`define SSE_CMD_JOIN_IND    16'hfc07
`define SSE_CMD_PEER_IND    16'hfc08
`define SSE_CMD_RESET_CFG   16'h0026
`define SSE_CMD_ADD_STATUS  16'h0030

// Status byte: shared bits and per-master flag positions.
`define SSE_SHARED_MASK     8'h9f
`define SSE_STS_COLD_BIT    5
`define SSE_STS_CFG_BIT     6

// Trigger field of an indication.
`define SSE_TRIG_COLD       0
`define SSE_TRIG_CFG        1
`define SSE_TRIG_MASK       8'h03

// Payload lengths in bytes.
`define SSE_LEN_IND         3'd6
`define SSE_LEN_JOIN        3'd1
`define SSE_LEN_EMPTY       3'd0

// Register word indices (byte address bits 5:2).
`define SSE_REG_CTRL        4'h0
`define SSE_REG_OWN_STATUS  4'h1
`define SSE_REG_OWN_COUNT   4'h2
`define SSE_REG_JOIN        4'h3
`define SSE_REG_BURST_CMD   4'h4
`define SSE_REG_BURST_PER   4'h5
`define SSE_REG_DEBOUNCE    4'h6
`define SSE_REG_MASTER_SEL  4'h7
`define SSE_REG_COMBINED    4'h8
`define SSE_REG_COMB_COUNT  4'h9
`define SSE_REG_PEER_STATUS 4'ha
`define SSE_REG_PEER_COUNT  4'hb

// Control register fields, and the burst enable bit of the burst command register.
`define SSE_CTRL_NOTIFY_EN  0
`define SSE_CTRL_EV_COLD    1
`define SSE_CTRL_EV_CFG     2
`define SSE_BURST_EN_BIT    16

`endif

//--- design/sse_status_sync.v
// Status synchronisation engine with Avalon-MM registers and board frame ports.
`timescale 1ns/1ps
`include "sse_consts.vh"
// Behaviour
// RULE1: Own changes leave as 64518; board changes arrive as 64520.
// RULE2: Requests carry the sender's status; responses the responder's.
// RULE3: Mirror the board's status and merge it when needed.
// RULE4: Change counters are 16-bit unsigned, own and peer apart.
// RULE5: Shared status bits 0x40 and 0x20 stay zero.
// RULE6: Per-master cold and config flags, set locally or by trigger.
// RULE7: A master's first command clears only its own cold flag.
// RULE8: Command 38 clears only the sender's config flag.
// RULE9: The board sends 64520 on any status change.
// RULE10: Cold and config events travel only in trigger byte 5.
// RULE11: A trigger goes out in exactly one indication.
// RULE12: The board reports unknown bits as zero.
// RULE13: The board overwrites its mirror on 64518 and replies its status.
// RULE14: The board sets all its masters' flags per trigger.
// RULE15: The board echoes no trigger without a local event.
// RULE16: Master status is own shared OR its flags OR peer shared.
// RULE17: Extended status and status three are own OR peer.
// RULE18: Reported counter is own plus peer.
// RULE19: Each join status change sends 64519 with the mode.
// RULE20: A burst command is refreshed from the board at its period.
// RULE21: Burst refresh requests carry an empty payload.
// RULE22: With notify on, poll 48 every half de-bounce period.
// RULE23: Trigger 0x01 cold, 0x02 config; bytes 0-4 status and count.
// RULE24: The summed counter wraps modulo 65536.
module sse_status_sync #(
    parameter NUM_MASTERS = 4,
    parameter MIDX_W      = 2,
    parameter PERIOD_W    = 24
) (
    // Clock and reset.
    input  wire                 sys_clk_i,
    input  wire                 sys_rst_i,
    // Avalon-MM register slave.
    input  wire [5:0]           avs_address_i,
    input  wire                 avs_read_i,
    input  wire                 avs_write_i,
    input  wire [31:0]          avs_writedata_i,
    input  wire [3:0]           avs_byteenable_i,
    output reg  [31:0]          avs_readdata_o,
    output reg                  avs_waitrequest_o,
    // Frames received from the instrument board.
    input  wire                 rx_valid_i,
    input  wire                 rx_is_resp_i,
    input  wire [15:0]          rx_cmd_i,
    input  wire [7:0]           rx_status_i,
    input  wire [7:0]           rx_ext_i,
    input  wire [7:0]           rx_std3_i,
    input  wire [15:0]          rx_count_i,
    input  wire [7:0]           rx_flags_i,
    // Commands arriving from network masters, and the combined status returned.
    input  wire                 mst_valid_i,
    input  wire [15:0]          mst_cmd_i,
    input  wire [MIDX_W-1:0]    requesting_master_index_i,
    output reg                  mst_ans_valid_o,
    output reg  [7:0]           mst_status_o,
    output reg  [7:0]           mst_ext_o,
    output reg  [7:0]           mst_std3_o,
    output reg  [15:0]          mst_count_o,
    // Wireless operation mode from the network stack.
    input  wire [7:0]           join_mode_i,
    // Frames sent to the instrument board.
    output reg                  tx_valid_o,
    output reg                  tx_is_resp_o,
    output reg  [15:0]          tx_cmd_o,
    output reg  [2:0]           tx_len_o,
    output reg  [47:0]          tx_payload_o,
    input  wire                 tx_ready_i
);

    // Software-visible state.
    reg                     notify_en;
    reg  [7:0]              own_shared_status_byte;
    reg  [7:0]              own_extended_status;
    reg  [7:0]              own_std_status_three;
    reg  [15:0]             own_change_count;
    reg  [15:0]             burst_cmd;
    reg                     burst_en;
    reg  [PERIOD_W-1:0]     burst_period;
    reg  [PERIOD_W-1:0]     debounce;
    reg  [MIDX_W-1:0]       master_sel;
    // Board mirror; per-master flags, bit 2i cold, 2i+1 config.
    reg  [7:0]              peer_shared_status_byte;
    reg  [7:0]              peer_extended_status;
    reg  [7:0]              peer_std_status_three;
    reg  [15:0]             peer_change_count;
    reg  [2*NUM_MASTERS-1:0] per_master_event_flags;
    // Pending transmissions and timers.
    reg  [1:0]              pend_trig;
    reg                     pend_ind;
    reg                     pend_resp;
    reg                     pend_join;
    reg                     pend_poll;
    reg                     pend_burst;
    reg  [7:0]              join_last;
    reg  [PERIOD_W-1:0]     burst_cnt;
    reg  [PERIOD_W-1:0]     poll_cnt;

    // Byte-enable merge for register writes.
    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer k;
        begin
            be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[8*k +: 8] = new_v[8*k +: 8];
                end
            end
        end
    endfunction

    // Bus decode; a write lands while waitrequest is low.
    wire [3:0]  reg_idx = avs_address_i[5:2];
    wire        wr_en   = avs_write_i & ~avs_waitrequest_o;
    wire [31:0] wr_st   = be_merge({8'h00, own_std_status_three, own_extended_status,
                                    own_shared_status_byte}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] wr_cnt  = be_merge({16'h0000, own_change_count}, avs_writedata_i,
                                   avs_byteenable_i);
    wire [31:0] wr_ctl  = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
    wire        ev_cold = wr_en & (reg_idx == `SSE_REG_CTRL) & wr_ctl[`SSE_CTRL_EV_COLD];
    wire        ev_cfg  = wr_en & (reg_idx == `SSE_REG_CTRL) & wr_ctl[`SSE_CTRL_EV_CFG];

    // Next own status; reserved bits forced clear.
    reg  [7:0]  next_own_shared;
    reg  [7:0]  next_own_ext;
    reg  [7:0]  next_own_std3;
    reg  [15:0] next_own_count;
    always @* begin
        next_own_shared = own_shared_status_byte;
        next_own_ext    = own_extended_status;
        next_own_std3   = own_std_status_three;
        next_own_count  = own_change_count;
        if (wr_en && reg_idx == `SSE_REG_OWN_STATUS) begin
            next_own_shared = wr_st[7:0] & `SSE_SHARED_MASK;   // see RULE5
            next_own_ext    = wr_st[15:8];
            next_own_std3   = wr_st[23:16];
        end
        if (wr_en && reg_idx == `SSE_REG_OWN_COUNT) begin
            next_own_count = wr_cnt[15:0];
        end else if (ev_cfg) begin
            next_own_count = own_change_count + 16'h0001;    // see RULE4
        end
    end
    wire own_changed = (next_own_shared != own_shared_status_byte) |
                       (next_own_ext != own_extended_status) |
                       (next_own_std3 != own_std_status_three) |
                       (next_own_count != own_change_count) | ev_cold | ev_cfg;

    // Board indication, or the board's answer to ours.
    wire rx_ind  = rx_valid_i & ~rx_is_resp_i & (rx_cmd_i == `SSE_CMD_PEER_IND);  // see RULE1
    wire rx_ans  = rx_valid_i & rx_is_resp_i & (rx_cmd_i == `SSE_CMD_OWN_IND);
    wire rx_sync = rx_ind | rx_ans;
    wire trig_cold = ev_cold | (rx_sync & rx_flags_i[`SSE_TRIG_COLD]);
    wire trig_cfg  = ev_cfg | (rx_sync & rx_flags_i[`SSE_TRIG_CFG]);

    // Combined values; the counter sum keeps only its low 16 bits.
    wire [15:0] sum_count = own_change_count + peer_change_count;   // see RULE18, RULE24
    wire [7:0]  comb_ext  = own_extended_status | peer_extended_status;   // see RULE17
    wire [7:0]  comb_std3 = own_std_status_three | peer_std_status_three;
    wire [7:0]  sel_flags = {1'b0, per_master_event_flags[2*master_sel+1],
                             per_master_event_flags[2*master_sel], 5'h00};
    wire [7:0]  mst_flags = {1'b0, per_master_event_flags[2*requesting_master_index_i+1],
                             per_master_event_flags[2*requesting_master_index_i], 5'h00};

    // Timer expiry; poll period is half de-bounce, at least one cycle.
    wire [PERIOD_W-1:0] half_db   = (debounce >> 1) == {PERIOD_W{1'b0}} ?
                                    {{(PERIOD_W-1){1'b0}}, 1'b1} : (debounce >> 1);
    wire burst_on  = burst_en & (burst_period != {PERIOD_W{1'b0}});
    wire burst_hit = burst_on & (burst_cnt >= burst_period - {{(PERIOD_W-1){1'b0}}, 1'b1});
    wire poll_hit  = notify_en & (poll_cnt >= half_db - {{(PERIOD_W-1){1'b0}}, 1'b1});

    // Transmit launcher picks the highest-priority pending frame when idle.
    wire        tx_free  = ~tx_valid_o;
    wire        take_rsp = tx_free & pend_resp;
    wire        take_ind = tx_free & ~pend_resp & pend_ind;
    wire        take_jn  = tx_free & ~pend_resp & ~pend_ind & pend_join;
    wire        take_pl  = tx_free & ~pend_resp & ~pend_ind & ~pend_join & pend_poll;
    wire        take_bu  = tx_free & ~pend_resp & ~pend_ind & ~pend_join & ~pend_poll &
                           pend_burst;
    wire        take_st  = take_rsp | take_ind;
    wire [47:0] own_pay  = {6'h00, pend_trig, own_change_count, own_std_status_three,
                            own_extended_status, own_shared_status_byte};

    integer i;

    // Bus slave: one wait cycle; read data stand with waitrequest low.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
            avs_waitrequest_o <= 1'b0;
            case (reg_idx)
                `SSE_REG_CTRL:        avs_readdata_o <= {31'h0000_0000, notify_en};
                `SSE_REG_OWN_STATUS:  avs_readdata_o <= {8'h00, own_std_status_three,
                                                         own_extended_status,
                                                         own_shared_status_byte};
                `SSE_REG_OWN_COUNT:   avs_readdata_o <= {16'h0000, own_change_count};
                `SSE_REG_JOIN:        avs_readdata_o <= {24'h00_0000, join_last};
                `SSE_REG_BURST_CMD:   avs_readdata_o <= {15'h0000, burst_en, burst_cmd};
                `SSE_REG_BURST_PER:   avs_readdata_o <= {{(32-PERIOD_W){1'b0}}, burst_period};
                `SSE_REG_DEBOUNCE:    avs_readdata_o <= {{(32-PERIOD_W){1'b0}}, debounce};
                `SSE_REG_MASTER_SEL:  avs_readdata_o <= {{(32-MIDX_W){1'b0}}, master_sel};
                `SSE_REG_COMBINED:    avs_readdata_o <= {8'h00, comb_std3, comb_ext,
                    own_shared_status_byte | sel_flags | peer_shared_status_byte};  // see RULE16
                `SSE_REG_COMB_COUNT:  avs_readdata_o <= {16'h0000, sum_count};
                `SSE_REG_PEER_STATUS: avs_readdata_o <= {8'h00, peer_std_status_three,
                                                         peer_extended_status,
                                                         peer_shared_status_byte};
                `SSE_REG_PEER_COUNT:  avs_readdata_o <= {16'h0000, peer_change_count};
                default:              avs_readdata_o <= 32'h0000_0000;
            endcase
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Configuration registers written by software.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            notify_en    <= 1'b0;
            burst_cmd    <= 16'h0000;
            burst_en     <= 1'b0;
            burst_period <= {PERIOD_W{1'b0}};
            debounce     <= {PERIOD_W{1'b0}};
            master_sel   <= {MIDX_W{1'b0}};
        end else if (wr_en) begin
            case (reg_idx)
                `SSE_REG_CTRL:       notify_en <= wr_ctl[`SSE_CTRL_NOTIFY_EN];
                `SSE_REG_BURST_CMD: begin
                    burst_cmd <= avs_writedata_i[15:0];
                    burst_en  <= avs_writedata_i[`SSE_BURST_EN_BIT];
                end
                `SSE_REG_BURST_PER:  burst_period <= avs_writedata_i[PERIOD_W-1:0];
                `SSE_REG_DEBOUNCE:   debounce <= avs_writedata_i[PERIOD_W-1:0];
                `SSE_REG_MASTER_SEL: master_sel <= avs_writedata_i[MIDX_W-1:0];
                default:             notify_en <= notify_en;
            endcase
        end
    end

    // Own status, board mirror and per-master flags.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            own_shared_status_byte  <= 8'h00;
            own_extended_status     <= 8'h00;
            own_std_status_three    <= 8'h00;
            own_change_count        <= 16'h0000;
            peer_shared_status_byte <= 8'h00;
            peer_extended_status    <= 8'h00;
            peer_std_status_three   <= 8'h00;
            peer_change_count       <= 16'h0000;
            per_master_event_flags  <= {NUM_MASTERS{2'b01}};   // Power-up is a cold start.
        end else begin
            own_shared_status_byte <= next_own_shared;
            own_extended_status    <= next_own_ext;
            own_std_status_three   <= next_own_std3;
            own_change_count       <= next_own_count;
            // Board values overwrite the mirror; flag bits stay out.
            if (rx_sync) begin
                peer_shared_status_byte <= rx_status_i & `SSE_SHARED_MASK;  // see RULE3, RULE10
                peer_extended_status    <= rx_ext_i;
                peer_std_status_three   <= rx_std3_i;
                peer_change_count       <= rx_count_i;
            end
            // A set in the same cycle as a master's clear wins.
            for (i = 0; i < NUM_MASTERS; i = i + 1) begin
                per_master_event_flags[2*i] <= trig_cold |                       // see RULE6
                    (per_master_event_flags[2*i] &
                     ~(mst_valid_i && requesting_master_index_i == i));          // see RULE7
                per_master_event_flags[2*i+1] <= trig_cfg |
                    (per_master_event_flags[2*i+1] &
                     ~(mst_valid_i && requesting_master_index_i == i &&
                       mst_cmd_i == `SSE_CMD_RESET_CFG));                        // see RULE8
            end
        end
    end

    // Answer to a master, taken before its own clears.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mst_ans_valid_o <= 1'b0;
            mst_status_o    <= 8'h00;
            mst_ext_o       <= 8'h00;
            mst_std3_o      <= 8'h00;
            mst_count_o     <= 16'h0000;
        end else begin
            mst_ans_valid_o <= mst_valid_i;
            if (mst_valid_i) begin
                mst_status_o <= own_shared_status_byte | mst_flags |
                                peer_shared_status_byte;                         // see RULE16
                mst_ext_o    <= comb_ext;                                        // see RULE17
                mst_std3_o   <= comb_std3;
                mst_count_o  <= sum_count;                                       // see RULE18
            end
        end
    end

    // Burst refresh and event poll timers.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            burst_cnt <= {PERIOD_W{1'b0}};
            poll_cnt  <= {PERIOD_W{1'b0}};
        end else begin
            burst_cnt <= (!burst_on || burst_hit) ? {PERIOD_W{1'b0}} :
                         burst_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
            poll_cnt  <= (!notify_en || poll_hit) ? {PERIOD_W{1'b0}} :
                         poll_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
        end
    end

    // Pending work and the transmit frame register.
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pend_trig    <= 2'b01;
            pend_ind     <= 1'b1;
            pend_resp    <= 1'b0;
            pend_join    <= 1'b0;
            pend_poll    <= 1'b0;
            pend_burst   <= 1'b0;
            join_last    <= 8'h00;
            tx_valid_o   <= 1'b0;
            tx_is_resp_o <= 1'b0;
            tx_cmd_o     <= 16'h0000;
            tx_len_o     <= `SSE_LEN_EMPTY;
            tx_payload_o <= 48'h0000_0000_0000;
        end else begin
            // A trigger leaves with one frame; a same-cycle event stays.
            pend_trig  <= (take_st ? 2'b00 : pend_trig) | {ev_cfg, ev_cold};    // see RULE11
            pend_ind   <= (pend_ind & ~take_ind) | own_changed;                  // see RULE1
            pend_resp  <= (pend_resp & ~take_rsp) | rx_ind;                      // see RULE2
            join_last  <= join_mode_i;
            pend_join  <= (pend_join & ~take_jn) | (join_mode_i != join_last);   // see RULE19
            pend_poll  <= notify_en & ((pend_poll & ~take_pl) | poll_hit);      // see RULE22
            pend_burst <= burst_en & ((pend_burst & ~take_bu) | burst_hit);     // see RULE20
            if (tx_valid_o && tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end else if (take_st) begin
                tx_valid_o   <= 1'b1;
                tx_is_resp_o <= take_rsp;
                tx_cmd_o     <= take_rsp ? `SSE_CMD_PEER_IND : `SSE_CMD_OWN_IND;
                tx_len_o     <= `SSE_LEN_IND;
                tx_payload_o <= own_pay;                                  // see RULE2, RULE23
            end else if (take_jn) begin
                tx_valid_o   <= 1'b1;
                tx_is_resp_o <= 1'b0;
                tx_cmd_o     <= `SSE_CMD_JOIN_IND;
                tx_len_o     <= `SSE_LEN_JOIN;
                tx_payload_o <= {40'h00_0000_0000, join_last};
            end else if (take_pl || take_bu) begin
                tx_valid_o   <= 1'b1;
                tx_is_resp_o <= 1'b0;
                tx_cmd_o     <= take_pl ? `SSE_CMD_ADD_STATUS : burst_cmd;
                tx_len_o     <= `SSE_LEN_EMPTY;                                  // see RULE21
                tx_payload_o <= 48'h0000_0000_0000;
            end
        end
    end

endmodule

//--- verification/sse_status_sync_assertions.sv
// Port checker for the status synchronisation engine.
`timescale 1ns/1ps
module sse_status_sync_assertions (
    input wire        sys_clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire        mst_valid_i, mst_ans_valid_o, tx_valid_o, tx_ready_i,
    input wire [15:0] tx_cmd_o,
    input wire [2:0]  tx_len_o,
    input wire [47:0] tx_payload_o,
    input wire [7:0]  join_mode_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Bus and master answers follow their requests by exactly one cycle.
    AST_BUS_ANS: assert property ((avs_read_i | avs_write_i) & avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus not answered");
    AST_BUS_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_ANS_NEXT: assert property (mst_valid_i |=> mst_ans_valid_o)
        else $error("master not answered");
    AST_ANS_ONLY: assert property (!mst_valid_i |=> !mst_ans_valid_o)
        else $error("spurious master answer");
    // A frame holds steady until taken and then drops for a cycle.
    AST_TX_HOLD: assert property (tx_valid_o & !tx_ready_i
        |=> tx_valid_o & $stable(tx_payload_o) & $stable(tx_cmd_o)) else $error("frame moved");
    AST_TX_GAP: assert property (tx_valid_o & tx_ready_i |=> !tx_valid_o)
        else $error("no gap after frame");
    // Own indications keep their layout; a join change brings a join frame within 400 cycles.
    AST_IND_FMT: assert property (tx_valid_o && tx_cmd_o == 16'hfc06 |->
        tx_len_o == 3'd6 && tx_payload_o[6:5] == 2'b00 && tx_payload_o[47:42] == 6'h00)
        else $error("bad indication layout");
    AST_JOIN_SENT: assert property ($changed(join_mode_i) |-> ##[1:400]
        (tx_valid_o && tx_cmd_o == 16'hfc07 && tx_len_o == 3'd1)) else $error("join not sent");
    cover property (tx_valid_o && tx_ready_i && tx_cmd_o == 16'h0030);
    cover property (tx_valid_o && tx_ready_i && tx_cmd_o == 16'hfc07);
    cover property (mst_ans_valid_o && tx_valid_o);
endmodule
bind sse_status_sync sse_status_sync_assertions sse_status_sync_assertions_inst (.sys_clk_i,
    .sys_rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .mst_valid_i, .mst_ans_valid_o,
    .tx_valid_o, .tx_ready_i, .tx_cmd_o, .tx_len_o, .tx_payload_o, .join_mode_i);

//--- verification/sse_board_model.sv
// Instrument board model: stalls frames, answers status indications.
`timescale 1ns/1ps
module sse_board_model (
    input  wire       clk_i, slow_i, ind_i, tx_valid_i,
    input  wire [7:0] st_i, fl_i,
    input  wire [15:0] cnt_i, tx_cmd_i,
    output reg        tx_ready_o, rx_valid_o, rx_is_resp_o,
    output reg [15:0] rx_cmd_o, rx_count_o,
    output reg [7:0]  rx_status_o, rx_ext_o, rx_std3_o, rx_flags_o
);
    initial {tx_ready_o, rx_valid_o, rx_is_resp_o} = 3'b000;
    // Unused bits go out as zero, triggers are never echoed, idle fields toggle.
    always @(posedge clk_i) begin
        tx_ready_o <= !slow_i || ($urandom % 4 == 0);
        rx_valid_o <= ind_i || (tx_valid_i && tx_ready_o && tx_cmd_i == 16'hfc06);
        rx_is_resp_o <= !ind_i;
        rx_cmd_o <= ind_i ? 16'hfc08 : 16'hfc06;
        if (ind_i || tx_valid_i) begin
            {rx_status_o, rx_ext_o, rx_std3_o, rx_count_o} <=
                {st_i & 8'h9f, st_i[3:0], st_i[7:4], cnt_i[15:8], cnt_i};
            rx_flags_o <= ind_i ? fl_i : 8'h00;
        end else begin
            {rx_status_o, rx_ext_o, rx_std3_o, rx_count_o, rx_flags_o} <=
                ~{rx_status_o, rx_ext_o, rx_std3_o, rx_count_o, rx_flags_o};
        end
    end
endmodule

//--- verification/test_status_sync_engine.sv
// Self-checking bench for the status synchronisation engine.
`timescale 1ns/1ps
module test_status_sync_engine;
    reg  sys_clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0, mst_valid_i = 0;
    reg  slow = 0, ind = 0;
    reg  [5:0] avs_address_i = 0;
    reg  [31:0] avs_writedata_i = 0, rd;
    reg  [15:0] mst_cmd_i = 0, b_cnt = 16'hff80, o_cnt = 0, fr_cmd;
    reg  [1:0] requesting_master_index_i = 0;
    reg  [7:0] join_mode_i = 0, b_st = 8'h5b, o_st = 0, o_ex = 0, o_s3 = 0, fl = 0;
    reg  [2:0] fr_len;
    reg  [47:0] fr_pl;
    integer fails = 0, n_tests = 0, nfr = 0, nper = 0, cyc = 0, i;
    wire [3:0] avs_byteenable_i = 4'hf;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, mst_ans_valid_o, rx_valid_i, rx_is_resp_i, tx_valid_o, tx_is_resp_o;
    wire tx_ready_i;
    wire [7:0] mst_status_o, mst_ext_o, mst_std3_o, rx_status_i, rx_ext_i, rx_std3_i, rx_flags_i;
    wire [15:0] mst_count_o, rx_cmd_i, rx_count_i, tx_cmd_o;
    wire [2:0] tx_len_o;
    wire [47:0] tx_payload_o;
    wire [39:0] got = {mst_status_o, mst_ext_o, mst_std3_o, mst_count_o};
    sse_status_sync sse_status_sync_inst (.*);
    sse_board_model sse_board_model_inst (.clk_i(sys_clk_i), .slow_i(slow), .ind_i(ind),
        .tx_valid_i(tx_valid_o), .st_i(b_st), .fl_i(fl), .cnt_i(b_cnt), .tx_cmd_i(tx_cmd_o),
        .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_is_resp_o(rx_is_resp_i),
        .rx_cmd_o(rx_cmd_i), .rx_count_o(rx_count_i), .rx_status_o(rx_status_i),
        .rx_ext_o(rx_ext_i), .rx_std3_o(rx_std3_i), .rx_flags_o(rx_flags_i));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // Combined status seen by a master with the given flags.
    function [39:0] exp_comb(input [7:0] f);
        exp_comb = {(o_st | b_st) & 8'h9f | f, o_ex | {b_st[3:0], b_st[7:4]},
            o_s3 | b_cnt[15:8], o_cnt + b_cnt};
    endfunction
    task tally_and_finish;
        $display("counts: %0d compared, %0d failed", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [47:0] g, input [47:0] e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One Avalon request, held until waitrequest is sampled low.
    task bus(input w, input [5:0] a, input [31:0] d);
        {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, w, !w};
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'b00;
        @(posedge sys_clk_i);
    endtask
    task mcmd(input [1:0] m, input [15:0] c);
        {requesting_master_index_i, mst_cmd_i, mst_valid_i} <= {m, c, 1'b1};
        @(posedge sys_clk_i);
        mst_valid_i <= 0;
        @(posedge sys_clk_i);
    endtask
    task wfr(input integer n);
        while (nfr < n) @(posedge sys_clk_i);
    endtask
    // Record taken frames and cut a hang short.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            fails = fails + 1;
            tally_and_finish;
        end
        if (tx_valid_o && tx_ready_i) begin
            {fr_cmd, fr_len, fr_pl} <= {tx_cmd_o, tx_len_o, tx_payload_o};
            nfr <= nfr + 1;
            nper <= nper + (tx_len_o == 3'd0);
        end
    end
    initial begin
        i = $urandom(96647);
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 0;
        wfr(nfr + 1);
        chk({fr_cmd, fr_len, fr_pl[47:40]}, {16'hfc06, 3'd6, 8'h01});
        repeat (4) @(posedge sys_clk_i);
        for (i = 0; i < 5; i++) begin
            mcmd(i % 4, 16'd1);
            chk(got, exp_comb(i < 4 ? 8'h20 : 8'h00));
        end
        bus(1, 6'h00, 32'h4);
        o_cnt = o_cnt + 1;
        wfr(nfr + 1);
        chk(fr_pl[47:40], 8'h02);
        for (i = 0; i < 3; i++) begin
            mcmd(i == 2 ? 2'd3 : 2'd0, i == 0 ? 16'd38 : 16'd1);
            chk(got, exp_comb(i == 1 ? 8'h00 : 8'h40));
        end
        $display("flag tests done");
        for (i = 0; i < 3; i++) begin
            slow <= i[0];
            {o_s3, o_ex, o_st} = $urandom;
            o_cnt = i == 2 ? 16'hffff : 16'($urandom);
            bus(1, 6'h08, {16'h0, o_cnt});
            wfr(nfr + 1);
            bus(1, 6'h04, {8'h0, o_s3, o_ex, o_st});
            wfr(nfr + 1);
            chk({fr_pl[47:40], fr_pl[23:0]}, {8'h00, o_s3, o_ex, o_st & 8'h9f});
            mcmd(2, 16'd38);
            chk(got, exp_comb(i == 0 ? 8'h40 : 8'h00));
        end
        {b_st, b_cnt, fl, ind} <= {8'($urandom), 16'($urandom), 8'h01, 1'b1};
        @(posedge sys_clk_i);
        ind <= 0;
        wfr(nfr + 1);
        chk({fr_pl[47:40], fr_pl[7:0]}, {8'h00, o_st & 8'h9f});
        mcmd(1, 16'd1);
        chk(got, exp_comb(8'h60));
        join_mode_i <= 8'h80 | 8'($urandom);
        wfr(nfr + 1);
        chk({fr_cmd, fr_len, fr_pl[7:0]}, {16'hfc07, 3'd1, join_mode_i});
        bus(0, 6'h3c, 0);
        chk(rd, 0);
        bus(0, 6'h2c, 0);
        chk(rd[15:0], b_cnt);
        $display("status tests done");
        for (i = 0; i < 2; i++) begin
            bus(1, i ? 6'h18 : 6'h14, i ? 32'd20 : 32'd10);
            bus(1, i ? 6'h00 : 6'h10, i ? 32'h1 : 32'h10021);
            repeat (20) @(posedge sys_clk_i);
            nper = 0;
            repeat (100) @(posedge sys_clk_i);
            chk({fr_cmd, nper >= 9 && nper <= 11}, {i ? 16'h30 : 16'h21, 1'b1});
            bus(1, i ? 6'h00 : 6'h10, 0);
        end
        $display("refresh tests done");
        tally_and_finish;
    end
endmodule
